//--- design/ebcp_external_bus_cycle_phaser.sv
// Top of the external bus cycle phaser: sequences one external bus cycle
// through five programmable phases and drives the bus strobes.
// Assumes the core issues one request at a time and holds its fields stable
// while requestValid is high; external inputs are synchronous to core_clk.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Each cycle runs setup, command delay, write setup, access, hold in order.
// (R2) Phase lengths come from the addressed chip select's timing config.
// (R3) Setup lasts one or two periods, plus zero to three on window change.
// (R4) Command delay is zero to three periods; access one to thirty-two.
// (R5) Write setup or multiplexed turnaround is zero or one period.
// (R6) The final hold phase is zero to three periods.
// (R7) Read data is captured on the edge that raises the read strobe.
// (R8) The external module holds read data until the read strobe rises.
// (R9) A phase of zero length is skipped with no idle cycle.
module ebcp_external_bus_cycle_phaser
#(
	parameter int NUM_CS = 4,
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
)
(
	// Clock and reset
	input  wire logic                                core_clk,
	input  wire logic                                rstn,
	// Per chip select timing configuration
	input  wire logic [NUM_CS*ebcp_pkg::CFG_W-1:0]   chip_select_timing_config,
	// Core request
	input  wire logic                                requestValid,
	input  wire logic                                requestWrite,
	input  wire logic [$clog2(NUM_CS)-1:0]           requestCs,
	input  wire logic [ADDR_W-1:0]                   requestAddr,
	input  wire logic [DATA_W-1:0]                   requestWdata,
	input  wire logic                                requestUpperByte,
	input  wire logic                                windowChange,
	// Core answer
	output logic                                     requestReady,
	output logic                                     readValid,
	output logic [DATA_W-1:0]                        readData,
	// External bus
	output logic                                     reference_clock_out,
	output logic [ADDR_W-1:0]                        busAddr,
	output logic [NUM_CS-1:0]                        chipSelect_n,
	output logic                                     addrLatch,
	output logic                                     readStrobe_n,
	output logic                                     writeStrobe_n,
	output logic                                     upper_byte_enable_n,
	output logic [DATA_W-1:0]                        busDataOut,
	output logic                                     busDataOe,
	input  wire logic [DATA_W-1:0]                   busDataIn
);
	// A single chip select would leave the select index with no bits.
	if (NUM_CS < 2 || ADDR_W < 1 || DATA_W < 1)
	begin : g_param_check
		$error("Phaser parameters out of range.");
	end

	// =====================================================================
	// Configuration decode for the addressed chip select
	logic [ebcp_pkg::CFG_W-1:0]  cfg;
	logic [ebcp_pkg::CNT_W-1:0]  setupLen;
	logic [ebcp_pkg::CNT_W-1:0]  cmdLen;
	logic [ebcp_pkg::CNT_W-1:0]  wdataLen;
	logic [ebcp_pkg::CNT_W-1:0]  accLen;
	logic [ebcp_pkg::CNT_W-1:0]  holdLen;
	logic [ebcp_pkg::CFG_W-1:0]  curCfg;
	logic                        curWrite;
	logic [$clog2(NUM_CS)-1:0]   curCs;
	logic                        winChg;

	assign cfg = chip_select_timing_config[requestCs*ebcp_pkg::CFG_W +:
		ebcp_pkg::CFG_W]; // R2

	// Setup is 1 or 2 plus a 0..3 extension on window change, 5 at most.
	assign setupLen = ebcp_pkg::CNT_W'(curCfg[ebcp_pkg::F_SETUP])
		+ ebcp_pkg::CNT_ONE
		+ (winChg ? ebcp_pkg::CNT_W'(curCfg[ebcp_pkg::F_EXT +: ebcp_pkg::EXT_W])
		: ebcp_pkg::CNT_ZERO); // R3
	assign cmdLen = ebcp_pkg::CNT_W'(curCfg[ebcp_pkg::F_CMD +:
		ebcp_pkg::CMD_W]); // R4
	assign wdataLen = ebcp_pkg::CNT_W'(curCfg[ebcp_pkg::F_WDATA]); // R5
	// Access field holds length minus one, giving 1..32.
	assign accLen = curCfg[ebcp_pkg::F_ACC +: ebcp_pkg::ACC_W]; // R4
	assign holdLen = ebcp_pkg::CNT_W'(curCfg[ebcp_pkg::F_HOLD +:
		ebcp_pkg::HOLD_W]); // R6

	// =====================================================================
	// Phase sequencing
	ebcp_pkg::ebcp_phase_type phase;
	ebcp_pkg::ebcp_phase_type next_phase;
	logic                     phaseDone;
	logic                     load;
	logic [ebcp_pkg::CNT_W-1:0] loadValue;
	logic [ebcp_pkg::CNT_W-1:0] next_len;

	// Zero-length phases are skipped by choosing the next nonzero one.
	// The next_len value is the counter preset, one less than the phase
	// length, so that a 32-period access still fits the five-bit counter.
	always_comb
	begin
		next_phase = phase;
		next_len = ebcp_pkg::CNT_ZERO;
		case (phase)
			ebcp_pkg::EBCP_IDLE:
				if (requestValid)
					next_phase = ebcp_pkg::EBCP_SETUP;
			ebcp_pkg::EBCP_SETUP, ebcp_pkg::EBCP_CMD, ebcp_pkg::EBCP_WDATA:
				if (phaseDone)
				begin
					// R1 R9
					if (phase == ebcp_pkg::EBCP_SETUP && cmdLen != '0)
					begin
						next_phase = ebcp_pkg::EBCP_CMD;
						next_len = cmdLen - ebcp_pkg::CNT_ONE;
					end
					else if (phase != ebcp_pkg::EBCP_WDATA && wdataLen != '0)
					begin
						next_phase = ebcp_pkg::EBCP_WDATA;
						next_len = wdataLen - ebcp_pkg::CNT_ONE;
					end
					else
					begin
						next_phase = ebcp_pkg::EBCP_ACC;
						next_len = accLen;
					end
				end
			ebcp_pkg::EBCP_ACC:
				if (phaseDone)
				begin
					// R1 R9
					next_phase = (holdLen != '0) ? ebcp_pkg::EBCP_HOLD
						: ebcp_pkg::EBCP_IDLE;
					next_len = (holdLen != '0)
						? holdLen - ebcp_pkg::CNT_ONE : ebcp_pkg::CNT_ZERO;
				end
			ebcp_pkg::EBCP_HOLD:
				if (phaseDone)
					next_phase = ebcp_pkg::EBCP_IDLE;
			default:
				next_phase = ebcp_pkg::EBCP_IDLE;
		endcase
	end

	// Counter holds remaining periods minus one; it expires in the last one.
	assign load = (next_phase != phase) || (phase == ebcp_pkg::EBCP_IDLE);
	assign loadValue = (next_phase == ebcp_pkg::EBCP_SETUP)
		? ebcp_pkg::CNT_W'(cfg[ebcp_pkg::F_SETUP]) + (windowChange
		? ebcp_pkg::CNT_W'(cfg[ebcp_pkg::F_EXT +: ebcp_pkg::EXT_W])
		: ebcp_pkg::CNT_ZERO)
		: next_len;

	ebcp_down_counter
	#(
		.WIDTH (ebcp_pkg::CNT_W)
	)
	u_counter
	(
		.core_clk  (core_clk),
		.rstn      (rstn),
		.load      (load),
		.loadValue (loadValue),
		.expired   (phaseDone)
	);

	wire startCycle = (phase == ebcp_pkg::EBCP_IDLE) && requestValid;
	wire readEnd    = (phase == ebcp_pkg::EBCP_ACC) && phaseDone && !curWrite;
	wire inCycle    = (next_phase != ebcp_pkg::EBCP_IDLE);
	wire strobeOn   = (next_phase == ebcp_pkg::EBCP_ACC);
	wire dataDrive  = curWrite && (next_phase == ebcp_pkg::EBCP_WDATA
		|| next_phase == ebcp_pkg::EBCP_ACC
		|| next_phase == ebcp_pkg::EBCP_HOLD);

	// =====================================================================
	// Registers
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			phase <= ebcp_pkg::EBCP_IDLE;
			curCfg <= '0;
			curWrite <= 1'b0;
			curCs <= '0;
			winChg <= 1'b0;
		end
		else
		begin
			phase <= next_phase;
			if (startCycle)
			begin
				curCfg <= cfg; // R2
				curWrite <= requestWrite;
				curCs <= requestCs;
				winChg <= windowChange;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			busAddr <= '0;
			upper_byte_enable_n <= 1'b1;
			busDataOut <= '0;
			readData <= '0;
			readValid <= 1'b0;
		end
		else
		begin
			if (startCycle)
			begin
				busAddr <= requestAddr;
				upper_byte_enable_n <= !requestUpperByte;
				busDataOut <= requestWdata;
			end
			readValid <= readEnd;
			if (readEnd)
				readData <= busDataIn; // R7 R8
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			chipSelect_n <= '1;
			addrLatch <= 1'b0;
			readStrobe_n <= 1'b1;
			writeStrobe_n <= 1'b1;
			busDataOe <= 1'b0;
			requestReady <= 1'b0;
			reference_clock_out <= 1'b0;
		end
		else
		begin
			chipSelect_n <= inCycle ? ~(NUM_CS'(1) << (startCycle ? requestCs
				: curCs)) : '1;
			addrLatch <= (next_phase == ebcp_pkg::EBCP_SETUP);
			readStrobe_n <= !(strobeOn && (startCycle ? !requestWrite
				: !curWrite)); // R7
			writeStrobe_n <= !(strobeOn && curWrite);
			busDataOe <= dataDrive;
			requestReady <= startCycle;
			reference_clock_out <= !reference_clock_out;
		end
	end

	// =====================================================================
	// Checks
	sequence s_accessEnd;
		phase == ebcp_pkg::EBCP_ACC && phaseDone;
	endsequence

	a_setup_bounds: assert property (@(posedge core_clk) disable iff (!rstn)
		phase == ebcp_pkg::EBCP_SETUP
		|-> setupLen >= ebcp_pkg::CNT_W'(ebcp_pkg::SETUP_MIN)
		&& setupLen <= ebcp_pkg::CNT_W'(ebcp_pkg::SETUP_MAX_TOT)) // R3
		else $error("Setup length out of range.");
	a_cycle_start: assert property (@(posedge core_clk) disable iff (!rstn)
		startCycle |=> phase == ebcp_pkg::EBCP_SETUP) // R1
		else $error("Cycle did not start with setup.");
	a_setup_next: assert property (@(posedge core_clk) disable iff (!rstn)
		phase == ebcp_pkg::EBCP_SETUP && phaseDone |=>
		phase != ebcp_pkg::EBCP_IDLE && phase != ebcp_pkg::EBCP_HOLD) // R1
		else $error("Setup left to wrong phase.");
	a_cmd_skip: assert property (@(posedge core_clk) disable iff (!rstn)
		phase == ebcp_pkg::EBCP_SETUP && phaseDone && cmdLen == '0 |=>
		phase != ebcp_pkg::EBCP_CMD) // R9
		else $error("Zero command delay not skipped.");
	a_wdata_len: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(phase == ebcp_pkg::EBCP_WDATA) |=>
		phase != ebcp_pkg::EBCP_WDATA) // R5
		else $error("Write setup longer than one period.");
	a_read_capture: assert property (@(posedge core_clk) disable iff (!rstn)
		s_accessEnd ##0 !curWrite |=> readValid && $rose(readStrobe_n)
		&& readData == $past(busDataIn)) // R7
		else $error("Read data not captured at strobe end.");
	a_strobe_access: assert property (@(posedge core_clk) disable iff (!rstn)
		phase == ebcp_pkg::EBCP_ACC && !curWrite |-> !readStrobe_n) // R4
		else $error("Read strobe missing in access.");
	a_write_drive: assert property (@(posedge core_clk) disable iff (!rstn)
		phase == ebcp_pkg::EBCP_ACC && curWrite |-> !writeStrobe_n
		&& busDataOe) // R4
		else $error("Write strobe or data drive missing in access.");
	a_hold_end: assert property (@(posedge core_clk) disable iff (!rstn)
		s_accessEnd ##0 holdLen == '0 |=> phase == ebcp_pkg::EBCP_IDLE) // R6
		else $error("Zero hold not skipped.");
	a_cfg_stable: assert property (@(posedge core_clk) disable iff (!rstn)
		phase != ebcp_pkg::EBCP_IDLE && !$past(startCycle) |->
		$stable(curCfg)) // R2
		else $error("Timing config changed mid cycle.");
endmodule

//--- design/ebcp_pkg.sv
// Package for the external bus cycle phaser: phase codes, field widths and
// timing limits used by the sequencer, which sizes its phase counter from CNT_W.
// Assumes a single core clock domain with synchronous active-low reset.
package ebcp_pkg;

	// =====================================================================
	// Phase encoding (one-hot)
	localparam int NUM_PHASES = 6;
	typedef enum logic [5:0]
	{
		EBCP_IDLE  = 6'b00_0001,
		EBCP_SETUP = 6'b00_0010,
		EBCP_CMD   = 6'b00_0100,
		EBCP_WDATA = 6'b00_1000,
		EBCP_ACC   = 6'b01_0000,
		EBCP_HOLD  = 6'b10_0000
	} ebcp_phase_type;

	// =====================================================================
	// Configuration field widths and limits, in cpu_clock_period units
	localparam int SETUP_W       = 1;
	localparam int EXT_W         = 2;
	localparam int CMD_W         = 2;
	localparam int ACC_W         = 5;
	localparam int HOLD_W        = 2;
	localparam int CFG_W         = SETUP_W + EXT_W + CMD_W + 1 + ACC_W + HOLD_W;
	localparam int CNT_W         = 5;
	localparam int SETUP_MIN     = 1;
	localparam int ACC_MIN       = 1;
	localparam int SETUP_MAX_TOT = 5;
	localparam int ACC_MAX       = 32;

	// Field positions inside one chip_select_timing_config word.
	localparam int F_SETUP = 0;
	localparam int F_EXT   = 1;
	localparam int F_CMD   = 3;
	localparam int F_WDATA = 5;
	localparam int F_ACC   = 6;
	localparam int F_HOLD  = 11;

	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

endpackage

//--- design/ebcp_down_counter.sv
// Phase length down counter used by the bus cycle phaser.
// Assumes the loader presents a length already reduced by one.
`timescale 1ns/1ps
module ebcp_down_counter
#(
	parameter int WIDTH = 5
)
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadValue,
	// Status
	output logic                  expired
);
	logic [WIDTH-1:0] count;

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			count <= '0;
		else if (load)
			count <= loadValue;
		else if (count != '0)
			count <= count - WIDTH'(1);
	end

	assign expired = (count == '0);
endmodule

//--- tb/ebcp_ext_memory.sv
// Behavioural external memory that answers the phaser's read cycles.
// Assumes it sees the phaser's bus outputs on the same core clock.
`timescale 1ns/1ps
module ebcp_ext_memory
#(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
)
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rstn,
	// Bus from the phaser
	input  wire logic [ADDR_W-1:0] busAddr,
	input  wire logic              readStrobe_n,
	// Read data to the phaser
	output logic      [DATA_W-1:0] busDataIn
);
	// =================================================================
	// Read data path
	logic [DATA_W-1:0] lastData;
	wire  [DATA_W-1:0] memData = {busAddr[7:0], ~busAddr[7:0]};

	// Once the strobe has risen the bus shows the inverse, so a late
	// capture cannot pass by luck.
	assign busDataIn = readStrobe_n ? ~lastData : memData;

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			lastData <= '0;
		else if (!readStrobe_n)
			lastData <= memData;
	end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the bus cycle phaser: every chip select with its
// own timing word, reads and writes, with and without window change.
// Assumes the behavioural memory model on the read data input.
`timescale 1ns/1ps
module tb_top;
	// =================================================================
	// Signals
	localparam int NCS = 4;
	localparam int CW  = ebcp_pkg::CFG_W;
	logic             core_clk;
	logic             rstn;
	logic [NCS*CW-1:0] cfg;
	logic             requestValid, requestWrite, requestUpperByte;
	logic             windowChange, requestReady, readValid;
	logic [1:0]       requestCs;
	logic [23:0]      requestAddr, busAddr;
	logic [15:0]      requestWdata, readData, busDataOut, busDataIn;
	logic [NCS-1:0]   chipSelect_n;
	logic             refClk, addrLatch, readStrobe_n, writeStrobe_n;
	logic             upperByte_n, busDataOe;
	int               miscompares = 0;
	int               samplesChecked = 0;
	int sL[NCS] = '{1, 2, 1, 2};
	int eL[NCS] = '{0, 3, 2, 1};
	int cL[NCS] = '{0, 3, 1, 2};
	int wL[NCS] = '{0, 1, 0, 1};
	int aL[NCS] = '{1, 32, 5, 16};
	int hL[NCS] = '{0, 3, 2, 1};

	// =================================================================
	// Design and far side
	ebcp_external_bus_cycle_phaser dut_u (.core_clk(core_clk), .rstn(rstn),
		.chip_select_timing_config(cfg), .requestValid(requestValid),
		.requestWrite(requestWrite), .requestCs(requestCs),
		.requestAddr(requestAddr), .requestWdata(requestWdata),
		.requestUpperByte(requestUpperByte), .windowChange(windowChange),
		.requestReady(requestReady), .readValid(readValid),
		.readData(readData), .reference_clock_out(refClk),
		.busAddr(busAddr), .chipSelect_n(chipSelect_n),
		.addrLatch(addrLatch), .readStrobe_n(readStrobe_n),
		.writeStrobe_n(writeStrobe_n), .upper_byte_enable_n(upperByte_n),
		.busDataOut(busDataOut), .busDataOe(busDataOe),
		.busDataIn(busDataIn));
	ebcp_ext_memory mem_u (.core_clk(core_clk), .rstn(rstn),
		.busAddr(busAddr), .readStrobe_n(readStrobe_n),
		.busDataIn(busDataIn));

	// =================================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checked %0d, miscompares %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One bus cycle; phases are told apart by the strobes seen at each
	// falling edge, so a phase out of order shows as a step backwards.
	task automatic run(input int cs, input logic wr, input logic wc);
		logic [23:0] ad;
		int n[4];
		int ph, cur, k;
		logic seen;
		logic prevRef;
		ad = 24'h00_10A5 + 24'(cs * 256 + wr * 16 + wc);
		n = '{0, 0, 0, 0};
		ph = 0;
		seen = 0;
		@(negedge core_clk);
		requestValid = 1;
		requestWrite = wr;
		requestCs = 2'(cs);
		requestAddr = ad;
		requestWdata = ~ad[15:0];
		requestUpperByte = wc;
		windowChange = wc;
		k = 0;
		do @(negedge core_clk); while (requestReady !== 1'b1 && ++k < 20);
		chk(requestReady, 1'b1);
		requestValid = 0;
		k = 0;
		while ((chipSelect_n[cs] === 1'b0 || (!wr && !seen)) && k < 60)
		begin
			if (k > 0)
				chk(refClk, !prevRef);
			prevRef = refClk;
			if (readValid === 1'b1)
			begin
				seen = 1;
				chk({wr, readData}, {1'b0, ad[7:0], ~ad[7:0]});
			end
			if (chipSelect_n[cs] === 1'b0)
			begin
				cur = (addrLatch === 1'b1) ? 0 :
					((wr ? writeStrobe_n : readStrobe_n) === 1'b0) ? 2 :
					(n[2] > 0) ? 3 : 1;
				if (cur < ph)
					chk(cur, ph);
				ph = cur;
				n[cur]++;
				chk(busAddr, ad);
				chk(upperByte_n, !wc);
				chk(wr ? readStrobe_n : writeStrobe_n, 1);
				if (cur == 2 && wr)
					chk({busDataOe, busDataOut}, {1'b1, ~ad[15:0]});
			end
			@(negedge core_clk);
			k++;
		end
		chk(k < 60, 1'b1);
		chk(seen, !wr);
		chk(n[0], sL[cs] + (wc ? eL[cs] : 0));
		chk(n[1], cL[cs] + wL[cs]);
		chk(n[2], aL[cs]);
		chk(n[3], hL[cs]);
		chk(chipSelect_n, 4'hF);
	endtask

	// =================================================================
	// Clock, watchdog and main sequence
	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end

	initial
	begin
		#20000;
		miscompares++;
		end_of_test();
	end

	initial
	begin
		rstn = 0;
		requestValid = 0;
		requestWrite = 0;
		requestCs = 2'h0;
		requestAddr = 24'h00_0000;
		requestWdata = 16'h0000;
		requestUpperByte = 0;
		windowChange = 0;
		for (int i = 0; i < NCS; i++)
			cfg[i*CW +: CW] = {2'(hL[i]), 5'(aL[i] - 1), 1'(wL[i]),
				2'(cL[i]), 2'(eL[i]), 1'(sL[i] - 1)};
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1;
		chk({chipSelect_n, readStrobe_n, writeStrobe_n, busDataOe}, 7'h7E);
		for (int c = 0; c < NCS; c++)
			for (int w = 0; w < 2; w++)
				for (int x = 0; x < 2; x++)
					run(c, w[0], x[0]);
		end_of_test();
	end
endmodule
